// ==== src/dmac_defs.svh ====
// Register offsets, field positions, reset values and descriptor layout for the DMA channel
`ifndef DMAC_DEFS_SVH
`define DMAC_DEFS_SVH
`define DMAC_OFF_DST_UPPER 12'h000
`define DMAC_OFF_DST_HIGH 12'h004
`define DMAC_OFF_DST_LOW 12'h008
`define DMAC_OFF_SRC_UPPER 12'h00c
`define DMAC_OFF_SRC_HIGH 12'h010
`define DMAC_OFF_SRC_LOW 12'h014
`define DMAC_OFF_LIST_UPPER 12'h018
`define DMAC_OFF_LIST_HIGH 12'h01c
`define DMAC_OFF_LIST_LOW 12'h020
`define DMAC_OFF_REQUEST_SOURCE 12'h024
`define DMAC_OFF_CONTROL 12'h028
`define DMAC_OFF_COUNT 12'h02c
`define DMAC_OFF_PROC_CTL 12'h030
`define DMAC_BYTE_RESET 8'h00
`define DMAC_HALF_RESET 16'h0000
`define DMAC_PTR_RESET 24'h000000
`define DMAC_BW_RESET 2'h3
`define DMAC_CTL_EN 15
`define DMAC_CTL_KEEP 14
`define DMAC_CTL_WIDTH_HI 13
`define DMAC_CTL_WIDTH_LO 12
`define DMAC_CTL_DST_HI 11
`define DMAC_CTL_DST_LO 10
`define DMAC_CTL_SRC_HI 9
`define DMAC_CTL_SRC_LO 8
`define DMAC_CTL_IRQ_EN 7
`define DMAC_CTL_FOLLOW 6
`define DMAC_CTL_HALT 4
`define DMAC_STEP_FIXED 2'h0
`define DMAC_STEP_INC 2'h1
`define DMAC_STEP_DEC 2'h2
`define DMAC_WIDTH_BYTE 2'h0
`define DMAC_WIDTH_HALF 2'h1
`define DMAC_INC_BYTE 24'h000001
`define DMAC_INC_HALF 24'h000002
`define DMAC_INC_WORD 24'h000004
`define DMAC_DESC_SIZE 24'h000010
`define DMAC_DESC_CTL 24'h000000
`define DMAC_DESC_CNT 24'h000002
`define DMAC_DESC_DST 24'h000004
`define DMAC_DESC_SRC 24'h000008
`define DMAC_DESC_LINK 24'h00000c
`define DMAC_DESC_LAST 2'h3
`endif

// ==== src/dmac_pkg.sv ====
// Types shared by the DMA channel
package dmac_pkg;
  typedef enum logic [3:0] {
    DMAC_IDLE = 4'b0000,
    DMAC_FETCH = 4'b0001,
    DMAC_WAIT_REQ = 4'b0010,
    DMAC_READ = 4'b0011,
    DMAC_WRITE = 4'b0100,
    DMAC_THROTTLE = 4'b0101
  } dmac_state_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [23:0] addr;
    logic [1:0] size;
    logic [31:0] wdata;
  } dmac_bus_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } dmac_bus_rsp_t;
endpackage

// ==== src/dmac_channel.sv ====
// One DMA channel: APB registers, pointer stepping, descriptor fetch and bus sequencing
// Functional notes
// RULE_01: Destination pointer holds, increments or decrements per transfer by its step field.
// RULE_02: Pointer step is 1, 2 or 4 bytes by transfer width.
// RULE_03: Source pointer holds, increments or decrements per transfer by its step field.
// RULE_04: Each 24-bit pointer is three RW byte registers cleared at reset.
// RULE_05: List pointer fetches descriptors only in list mode; upper byte is watermark otherwise.
// RULE_06: Request source is the RW field bits 3:0 of request select.
// RULE_07: Channel state reads in bits 7:4 of request select, zero at reset.
// RULE_08: Watermark compare enabled only when nonzero, against low byte of decremented count.
// RULE_09: Watermark interrupt when irq enable, high count zero, low count equals watermark.
// RULE_10: Four bandwidth levels: all cycles, one per one, two or three operations.
// RULE_11: Direct mode: software loads registers and sets the enable bit.
// RULE_12: List mode: software builds descriptors then writes first descriptor address.
// RULE_13: On list start the descriptor loads control and pointers, list pointer untouched.
// RULE_14: After a descriptor completes, the next descriptor is fetched and transfers continue; the code stops instead if its halt bit is set.
// RULE_15: Software aligns each 16-byte descriptor on a 16-byte boundary.
// RULE_16: Descriptor: control at 0, count at 2, dest at 4, source at 8, link at C.
// RULE_17: Software reserves buffer memory before enabling the channel.
// RULE_18: Count drops by one per transfer; at zero stop or load next descriptor.
// RULE_19: Follow-link uses descriptor link; otherwise list pointer advances by 16.
// RULE_20: Writing the list pointer starts list-mode operation.
// RULE_21: Keep bit set means no descriptor write-back when a buffer closes.
// RULE_22: Descriptor words are read in ascending order, subject to bandwidth sharing.
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "dmac_defs.svh"

module dmac_channel
  import dmac_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] periph_req,
  input wire logic cpu_op_done,
  output dmac_bus_req_t bus_req,
  input wire dmac_bus_rsp_t bus_rsp,
  output logic watermark_irq,
  output logic buffer_end_irq
);

  logic [7:0] dst_upper, dst_high, dst_low;
  logic [7:0] src_upper, src_high, src_low;
  logic [7:0] list_upper, list_high, list_low;
  logic [3:0] request_source;
  logic [15:0] channel_control;
  logic [15:0] transfer_count;
  logic [1:0] bandwidth_level;
  logic list_mode;
  dmac_state_t state;
  logic [1:0] fetch_idx;
  logic [1:0] ops_seen;
  logic [31:0] data_hold;

  wire logic [23:0] destination_pointer = {dst_upper, dst_high, dst_low};
  wire logic [23:0] source_pointer = {src_upper, src_high, src_low};
  wire logic [23:0] list_pointer = {list_upper, list_high, list_low};
  wire logic [7:0] watermark_byte = list_upper; // RULE_05
  wire logic [1:0] transfer_width =
    channel_control[`DMAC_CTL_WIDTH_HI:`DMAC_CTL_WIDTH_LO];
  wire logic [1:0] destination_step_control =
    channel_control[`DMAC_CTL_DST_HI:`DMAC_CTL_DST_LO];
  wire logic [1:0] source_step_control =
    channel_control[`DMAC_CTL_SRC_HI:`DMAC_CTL_SRC_LO];
  wire logic buffer_end_irq_enable = channel_control[`DMAC_CTL_IRQ_EN];
  wire logic follow_list_link = channel_control[`DMAC_CTL_FOLLOW];

  wire logic apb_access = psel && penable;
  wire logic apb_write = apb_access && pwrite;
  wire logic bus_done = bus_rsp.ack && bus_req.req;
  wire logic xfer_done = (state == DMAC_WRITE) && bus_done;
  wire logic fetch_done = (state == DMAC_FETCH) && bus_done;
  wire logic last_word = fetch_done && (fetch_idx == `DMAC_DESC_LAST);
  wire logic [15:0] next_count = transfer_count - 16'h0001; // RULE_18
  wire logic count_end = xfer_done && (next_count == `DMAC_HALF_RESET);
  wire logic list_write = apb_write && (paddr == `DMAC_OFF_LIST_LOW);
  wire logic [3:0] channel_state = state;

  // ----------------------------------------------------------------
  // Pointer stepping
  // ----------------------------------------------------------------
  logic [23:0] step_size;
  always_comb begin
    unique case (transfer_width) // RULE_02
      `DMAC_WIDTH_BYTE: step_size = `DMAC_INC_BYTE;
      `DMAC_WIDTH_HALF: step_size = `DMAC_INC_HALF;
      default: step_size = `DMAC_INC_WORD;
    endcase
  end

  function automatic logic [23:0] step_ptr(input logic [23:0] p, input logic [1:0] ctl,
                                           input logic [23:0] s);
    unique case (ctl)
      `DMAC_STEP_INC: step_ptr = p + s;
      `DMAC_STEP_DEC: step_ptr = p - s;
      default: step_ptr = p;
    endcase
  endfunction

  wire logic [23:0] next_dst = step_ptr(destination_pointer, destination_step_control,
                                        step_size); // RULE_01
  wire logic [23:0] next_src = step_ptr(source_pointer, source_step_control,
                                        step_size); // RULE_03

  // ----------------------------------------------------------------
  // Descriptor word decode
  // ----------------------------------------------------------------
  // Each fetch is a 32-bit read; the first word packs control (low half) and count (high half).
  logic [23:0] fetch_addr;
  always_comb begin
    unique case (fetch_idx) // RULE_16
      2'h0: fetch_addr = list_pointer + `DMAC_DESC_CTL;
      2'h1: fetch_addr = list_pointer + `DMAC_DESC_DST;
      2'h2: fetch_addr = list_pointer + `DMAC_DESC_SRC;
      default: fetch_addr = list_pointer + `DMAC_DESC_LINK;
    endcase
  end

  // ----------------------------------------------------------------
  // Pointer registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      {dst_upper, dst_high, dst_low} <= `DMAC_PTR_RESET; // RULE_04
    end else if (fetch_done && fetch_idx == 2'h1) begin
      {dst_upper, dst_high, dst_low} <= bus_rsp.rdata[23:0]; // RULE_13
    end else if (xfer_done) begin
      {dst_upper, dst_high, dst_low} <= next_dst; // RULE_01
    end else if (apb_write) begin
      if (paddr == `DMAC_OFF_DST_UPPER) dst_upper <= pwdata[7:0];
      if (paddr == `DMAC_OFF_DST_HIGH) dst_high <= pwdata[7:0];
      if (paddr == `DMAC_OFF_DST_LOW) dst_low <= pwdata[7:0];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      {src_upper, src_high, src_low} <= `DMAC_PTR_RESET; // RULE_04
    end else if (fetch_done && fetch_idx == 2'h2) begin
      {src_upper, src_high, src_low} <= bus_rsp.rdata[23:0]; // RULE_13
    end else if (xfer_done) begin
      {src_upper, src_high, src_low} <= next_src; // RULE_03
    end else if (apb_write) begin
      if (paddr == `DMAC_OFF_SRC_UPPER) src_upper <= pwdata[7:0];
      if (paddr == `DMAC_OFF_SRC_HIGH) src_high <= pwdata[7:0];
      if (paddr == `DMAC_OFF_SRC_LOW) src_low <= pwdata[7:0];
    end
  end

  // The link word is held aside so the list pointer stays put while a descriptor is loading.
  logic [23:0] link_hold;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      link_hold <= `DMAC_PTR_RESET;
    end else if (last_word) begin
      link_hold <= bus_rsp.rdata[23:0];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      {list_upper, list_high, list_low} <= `DMAC_PTR_RESET; // RULE_04
    end else if (count_end && list_mode && !channel_control[`DMAC_CTL_HALT]) begin
      if (follow_list_link) begin
        {list_upper, list_high, list_low} <= link_hold; // RULE_19
      end else begin
        {list_upper, list_high, list_low} <= list_pointer + `DMAC_DESC_SIZE; // RULE_19
      end
    end else if (apb_write) begin
      if (paddr == `DMAC_OFF_LIST_UPPER) list_upper <= pwdata[7:0];
      if (paddr == `DMAC_OFF_LIST_HIGH) list_high <= pwdata[7:0];
      if (paddr == `DMAC_OFF_LIST_LOW) list_low <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Control, count, request select, bandwidth
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      channel_control <= `DMAC_HALF_RESET;
    end else if (fetch_done && fetch_idx == 2'h0) begin
      channel_control <= bus_rsp.rdata[15:0]; // RULE_13
    end else if (count_end && (!list_mode || channel_control[`DMAC_CTL_HALT])) begin
      channel_control[`DMAC_CTL_EN] <= 1'b0; // RULE_18
    end else if (apb_write && paddr == `DMAC_OFF_CONTROL) begin
      channel_control <= pwdata[15:0]; // RULE_11
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      transfer_count <= `DMAC_HALF_RESET;
    end else if (fetch_done && fetch_idx == 2'h0) begin
      transfer_count <= bus_rsp.rdata[31:16]; // RULE_16
    end else if (xfer_done) begin
      transfer_count <= next_count; // RULE_18
    end else if (apb_write && paddr == `DMAC_OFF_COUNT) begin
      transfer_count <= pwdata[15:0];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      request_source <= 4'h0;
      bandwidth_level <= `DMAC_BW_RESET;
    end else if (apb_write) begin
      if (paddr == `DMAC_OFF_REQUEST_SOURCE) request_source <= pwdata[3:0]; // RULE_06
      if (paddr == `DMAC_OFF_PROC_CTL) bandwidth_level <= pwdata[1:0];
    end
  end

  // Mode latches on whichever start happens; the list pointer write wins a tie.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      list_mode <= 1'b0;
    end else if (state == DMAC_IDLE && list_write) begin
      list_mode <= 1'b1; // RULE_20
    end else if (state == DMAC_IDLE && apb_write && paddr == `DMAC_OFF_CONTROL) begin
      list_mode <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  wire logic request_seen = periph_req[request_source];
  wire logic throttle_free = (bandwidth_level == 2'h0) || (ops_seen >= bandwidth_level);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= DMAC_IDLE;
      fetch_idx <= 2'h0;
    end else begin
      unique case (state)
        DMAC_IDLE: begin
          if (list_write) begin
            state <= DMAC_FETCH; // RULE_20
            fetch_idx <= 2'h0;
          end else if (apb_write && paddr == `DMAC_OFF_CONTROL && pwdata[`DMAC_CTL_EN]) begin
            state <= DMAC_WAIT_REQ; // RULE_11
          end
        end
        DMAC_FETCH: begin
          if (fetch_done) begin
            fetch_idx <= fetch_idx + 2'h1; // RULE_22
            if (last_word) state <= DMAC_WAIT_REQ;
          end
        end
        DMAC_WAIT_REQ: begin
          if (request_seen && throttle_free) state <= DMAC_READ;
        end
        DMAC_READ: begin
          if (bus_done) state <= DMAC_WRITE;
        end
        DMAC_WRITE: begin
          if (count_end) begin
            if (list_mode && !channel_control[`DMAC_CTL_HALT]) begin
              state <= DMAC_THROTTLE; // RULE_14
              fetch_idx <= 2'h0;
            end else begin
              state <= DMAC_IDLE;
            end
          end else if (bus_done) begin
            state <= DMAC_WAIT_REQ;
          end
        end
        DMAC_THROTTLE: begin
          if (throttle_free) state <= DMAC_FETCH; // RULE_22
        end
        default: state <= DMAC_IDLE;
      endcase
    end
  end

  // Counts processor operations since the last completed transfer write, holding at three.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ops_seen <= 2'h0;
    end else if (xfer_done) begin
      ops_seen <= 2'h0; // RULE_10
    end else if (cpu_op_done && ops_seen != 2'h3) begin
      ops_seen <= ops_seen + 2'h1; // RULE_10
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      data_hold <= 32'h00000000;
    end else if (state == DMAC_READ && bus_done) begin
      data_hold <= bus_rsp.rdata;
    end
  end

  always_comb begin
    bus_req = '0;
    bus_req.req = (state == DMAC_FETCH) || (state == DMAC_READ) || (state == DMAC_WRITE);
    bus_req.we = (state == DMAC_WRITE);
    bus_req.size = (state == DMAC_FETCH) ? 2'h2 : transfer_width;
    bus_req.wdata = data_hold;
    unique case (state)
      DMAC_FETCH: bus_req.addr = fetch_addr;
      DMAC_WRITE: bus_req.addr = destination_pointer;
      default: bus_req.addr = source_pointer;
    endcase
  end

  // ----------------------------------------------------------------
  // Interrupt pulses
  // ----------------------------------------------------------------
  // The keep-descriptor bit has no effect here because this channel never writes back.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      watermark_irq <= 1'b0;
      buffer_end_irq <= 1'b0;
    end else begin
      watermark_irq <= xfer_done && !list_mode && (watermark_byte != 8'h00) && // RULE_08
                       buffer_end_irq_enable && (next_count[15:8] == 8'h00) &&
                       (next_count[7:0] == watermark_byte); // RULE_09
      buffer_end_irq <= count_end && buffer_end_irq_enable; // RULE_21
    end
  end

  // ----------------------------------------------------------------
  // APB read side
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  always_comb begin
    pslverr = 1'b0;
    prdata = 32'h00000000;
    unique case (paddr)
      `DMAC_OFF_DST_UPPER: prdata[7:0] = dst_upper;
      `DMAC_OFF_DST_HIGH: prdata[7:0] = dst_high;
      `DMAC_OFF_DST_LOW: prdata[7:0] = dst_low;
      `DMAC_OFF_SRC_UPPER: prdata[7:0] = src_upper;
      `DMAC_OFF_SRC_HIGH: prdata[7:0] = src_high;
      `DMAC_OFF_SRC_LOW: prdata[7:0] = src_low;
      `DMAC_OFF_LIST_UPPER: prdata[7:0] = list_upper;
      `DMAC_OFF_LIST_HIGH: prdata[7:0] = list_high;
      `DMAC_OFF_LIST_LOW: prdata[7:0] = list_low;
      `DMAC_OFF_REQUEST_SOURCE: prdata[7:0] = {channel_state, request_source}; // RULE_07
      `DMAC_OFF_CONTROL: prdata[15:0] = channel_control;
      `DMAC_OFF_COUNT: prdata[15:0] = transfer_count;
      `DMAC_OFF_PROC_CTL: prdata[1:0] = bandwidth_level;
      default: pslverr = apb_access;
    endcase
  end

endmodule

// ==== dv/dmac_channel_props.sv ====
// Concurrent checks on the DMA channel ports
`timescale 1ns/1ps
`include "dmac_defs.svh"

module dmac_channel_props
  import dmac_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] periph_req,
  input wire logic cpu_op_done,
  input wire dmac_bus_req_t bus_req,
  input wire dmac_bus_rsp_t bus_rsp,
  input wire logic watermark_irq,
  input wire logic buffer_end_irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic wr_ack;
  logic rd_ack;
  assign wr_ack = bus_req.req && bus_req.we && bus_rsp.ack;
  assign rd_ack = bus_req.req && !bus_req.we && bus_rsp.ack;

  a_bus_hold: assert property (bus_req.req && !bus_rsp.ack |=> bus_req.req && $stable(bus_req))
    else $error("bus request changed before ack");
  a_state_write: assert property (psel && !pwrite && paddr == `DMAC_OFF_REQUEST_SOURCE && bus_req.req && bus_req.we |-> prdata[7:4] == 4'h4)
    else $error("channel state not write during bus write");
  a_list_back: assert property (psel && penable && pwrite && paddr == `DMAC_OFF_LIST_HIGH ##2 psel && !pwrite && paddr == `DMAC_OFF_LIST_HIGH |-> prdata[7:0] == $past(pwdata[7:0], 2))
    else $error("list pointer byte lost its written value");
  a_source_back: assert property (psel && penable && pwrite && paddr == `DMAC_OFF_REQUEST_SOURCE ##2 psel && !pwrite && paddr == `DMAC_OFF_REQUEST_SOURCE |-> prdata[3:0] == $past(pwdata[3:0], 2))
    else $error("request source field lost its written value");
  a_wm_pulse: assert property (watermark_irq |=> !watermark_irq)
    else $error("watermark interrupt longer than one cycle");
  a_wm_cause: assert property (watermark_irq |-> $past(wr_ack))
    else $error("watermark interrupt without a completed transfer");
  a_end_cause: assert property (buffer_end_irq |-> $past(wr_ack))
    else $error("buffer end without a completed transfer");
  a_fetch_order: assert property (rd_ack && bus_req.addr[3:2] != 2'h3 |=> !bus_req.req || bus_req.we || bus_req.addr == $past(bus_req.addr) + 24'h000004)
    else $error("descriptor words not read in ascending order");
  a_data_pass: assert property (rd_ack && bus_req.size == 2'h2 ##1 bus_req.req && bus_req.we |-> bus_req.wdata == $past(bus_rsp.rdata))
    else $error("written word differs from word read");

  c_watermark: cover property (watermark_irq);
  c_buffer_end: cover property (buffer_end_irq);
  c_slow_bus: cover property (bus_req.req && !bus_rsp.ack ##1 bus_req.req && !bus_rsp.ack);
endmodule

bind dmac_channel dmac_channel_props i_props (.core_clk(core_clk), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .periph_req(periph_req), .cpu_op_done(cpu_op_done),
  .bus_req(bus_req), .bus_rsp(bus_rsp), .watermark_irq(watermark_irq),
  .buffer_end_irq(buffer_end_irq));

// ==== dv/dmac_mem_model.sv ====
// Behavioural system bus memory that answers the channel's reads and writes
`timescale 1ns/1ps

module dmac_mem_model
  import dmac_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic slow,
  input wire dmac_bus_req_t bus_req,
  output dmac_bus_rsp_t bus_rsp
);
  // Buffers and 16-byte aligned descriptors are placed here by the bench before start
  logic [31:0] mem [0:63];
  logic [1:0] wait_cnt;

  // Read data turns over every idle cycle so stale data never looks valid
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bus_rsp.ack <= 1'b0;
      bus_rsp.rdata <= 32'h5a5a5a5a;
      wait_cnt <= 2'h0;
    end else if (bus_rsp.ack) begin
      bus_rsp.ack <= 1'b0;
      bus_rsp.rdata <= ~bus_rsp.rdata;
      wait_cnt <= 2'h0;
    end else if (bus_req.req && (!slow || wait_cnt == 2'h3)) begin
      bus_rsp.ack <= 1'b1;
      bus_rsp.rdata <= bus_req.we ? ~bus_rsp.rdata : mem[bus_req.addr[7:2]];
      if (bus_req.we) mem[bus_req.addr[7:2]] <= bus_req.wdata;
    end else begin
      bus_rsp.rdata <= ~bus_rsp.rdata;
      wait_cnt <= bus_req.req ? wait_cnt + 2'h1 : 2'h0;
    end
  end
endmodule

// ==== dv/tb_dma_channel_addressing_descriptors.sv ====
// Self-checking bench for the DMA channel
`timescale 1ns/1ps
`include "dmac_defs.svh"

module tb_dma_channel_addressing_descriptors
  import dmac_pkg::*;
;
  logic core_clk, resetn, psel, penable, pwrite, cpu_op_done, slow, ops_on, err, pready, pslverr;
  logic watermark_irq, buffer_end_irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] periph_req;
  logic [23:0] ptr;
  dmac_bus_req_t bus_req;
  dmac_bus_rsp_t bus_rsp;
  int errors, compares, cycles, wm_seen, end_seen;

  dmac_channel i_dut (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .periph_req(periph_req), .cpu_op_done(cpu_op_done), .bus_req(bus_req),
    .bus_rsp(bus_rsp), .watermark_irq(watermark_irq), .buffer_end_irq(buffer_end_irq));
  dmac_mem_model i_mem (.core_clk(core_clk), .resetn(resetn), .slow(slow), .bus_req(bus_req),
    .bus_rsp(bus_rsp));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Processor operations only tick while a scenario lets them
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    cpu_op_done <= ops_on && !cpu_op_done;
    if (watermark_irq === 1'b1) wm_seen <= wm_seen + 1;
    if (buffer_end_irq === 1'b1) end_seen <= end_seen + 1;
    if (cycles == 20000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Only the bench timeout ends a stalled access
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic set_ptr(input logic [11:0] a, input logic [23:0] v);
    apb(1'b1, a, 32'(v[23:16]));
    apb(1'b1, a + 12'h4, 32'(v[15:8]));
    apb(1'b1, a + 12'h8, 32'(v[7:0]));
  endtask

  task automatic get_ptr(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
    ptr[23:16] = rd[7:0];
    apb(1'b0, a + 12'h4, 32'h0);
    ptr[15:8] = rd[7:0];
    apb(1'b0, a + 12'h8, 32'h0);
    ptr[7:0] = rd[7:0];
  endtask

  task automatic wait_ends(input int n);
    // Polling the state field over APB waits, for up to 1000 reads, until n buffer ends are seen
    for (int k = 0; k < 1000 && end_seen < n; k++) begin
      apb(1'b0, `DMAC_OFF_REQUEST_SOURCE, 32'h0);
    end
    check(32'(end_seen), 32'(n));
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 10; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      check(rd, 32'h0);
    end
    apb(1'b0, `DMAC_OFF_PROC_CTL, 32'h0);
    check(rd, 32'(`DMAC_BW_RESET));
    apb(1'b1, 12'h040, 32'hffffffff);
    apb(1'b0, 12'h040, 32'h0);
    check({rd[30:0], err}, 32'h1);
  endtask

  // List low is left out: writing it would start list mode
  task automatic t_regs();
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 12'(4 * i), 32'hffffff00 | 32'(8'h31 + 8'(i)));
      apb(1'b0, 12'(4 * i), 32'h0);
      check(rd, 32'(8'h31 + 8'(i)));
    end
    apb(1'b1, `DMAC_OFF_REQUEST_SOURCE, 32'hff);
    apb(1'b0, `DMAC_OFF_REQUEST_SOURCE, 32'h0);
    check(rd, 32'h0f);
  endtask

  task automatic run_direct(input logic [1:0] w, ds, ss, bw, input logic [7:0] wm, exp_wm);
    logic [23:0] step, dexp, sexp;
    step = (w == `DMAC_WIDTH_BYTE) ? 24'h1 : (w == `DMAC_WIDTH_HALF) ? 24'h2 : 24'h4;
    dexp = ds == `DMAC_STEP_INC ? 24'hc0 + 3 * step : ds == `DMAC_STEP_DEC ? 24'hc0 - 3 * step : 24'hc0;
    sexp = ss == `DMAC_STEP_INC ? 24'h80 + 3 * step : ss == `DMAC_STEP_DEC ? 24'h80 - 3 * step : 24'h80;
    wm_seen = 0;
    end_seen = 0;
    ops_on <= 1'b0;
    periph_req <= 16'hffdf;
    apb(1'b1, `DMAC_OFF_REQUEST_SOURCE, 32'h5);
    apb(1'b1, `DMAC_OFF_PROC_CTL, 32'(bw));
    set_ptr(`DMAC_OFF_DST_UPPER, 24'hc0);
    set_ptr(`DMAC_OFF_SRC_UPPER, 24'h80);
    apb(1'b1, `DMAC_OFF_LIST_UPPER, 32'(wm));
    apb(1'b1, `DMAC_OFF_COUNT, 32'h3);
    apb(1'b1, `DMAC_OFF_CONTROL, {16'h0, 1'b1, 1'b0, w, ds, ss, 8'h80});
    repeat (30) @(posedge core_clk);
    apb(1'b0, `DMAC_OFF_COUNT, 32'h0);
    check(rd, 32'h3);
    periph_req <= 16'h0020;
    if (bw != 2'h0) begin
      repeat (60) @(posedge core_clk);
      apb(1'b0, `DMAC_OFF_COUNT, 32'h0);
      check({31'h0, rd[15:0] == 16'h0}, 32'h0);
    end
    ops_on <= 1'b1;
    wait_ends(1);
    check(32'(wm_seen), 32'(exp_wm));
    get_ptr(`DMAC_OFF_DST_UPPER);
    check(32'(ptr), 32'(dexp));
    get_ptr(`DMAC_OFF_SRC_UPPER);
    check(32'(ptr), 32'(sexp));
    apb(1'b0, `DMAC_OFF_REQUEST_SOURCE, 32'h0);
    check(rd, 32'h05);
  endtask

  task automatic t_direct();
    slow <= 1'b0;
    run_direct(`DMAC_WIDTH_BYTE, `DMAC_STEP_INC, `DMAC_STEP_DEC, 2'h0, 8'h2, 8'h1);
    slow <= 1'b1;
    run_direct(`DMAC_WIDTH_HALF, `DMAC_STEP_DEC, `DMAC_STEP_FIXED, 2'h2, 8'h0, 8'h0);
    run_direct(2'h2, `DMAC_STEP_FIXED, `DMAC_STEP_INC, 2'h3, 8'h0, 8'h0);
    slow <= 1'b0;
    run_direct(2'h2, `DMAC_STEP_INC, `DMAC_STEP_INC, 2'h1, 8'h1, 8'h1);
    for (int i = 0; i < 3; i++) check(i_mem.mem[48 + i], i_mem.mem[32 + i]);
  endtask

  // Chain 0x40 -> 0x50 by step, 0x50 -> 0x70 by link, 0x60 is a trap never visited
  task automatic t_list();
    logic [31:0] d [16];
    d = '{32'h0002a580, 32'hee0000a0, 32'hee000080, 32'h0,
          32'h0001a5c0, 32'hee0000b0, 32'hee000090, 32'hee000070,
          32'h0001a590, 32'hee0000c0, 32'hee000094, 32'h0,
          32'h0001a590, 32'hee0000b4, 32'hee000098, 32'h0};
    for (int i = 0; i < 16; i++) i_mem.mem[16 + i] = d[i];
    i_mem.mem[48] = 32'h0badc0de;
    wm_seen = 0;
    end_seen = 0;
    slow <= 1'b1;
    apb(1'b1, `DMAC_OFF_PROC_CTL, 32'h0);
    set_ptr(`DMAC_OFF_LIST_UPPER, 24'h010040);
    wait_ends(3);
    check(i_mem.mem[40], i_mem.mem[32]);
    check(i_mem.mem[41], i_mem.mem[33]);
    check(i_mem.mem[44], i_mem.mem[36]);
    check(i_mem.mem[45], i_mem.mem[38]);
    check(i_mem.mem[48], 32'h0badc0de);
    check(32'(wm_seen), 32'h0);
    // Last link came from the second descriptor; the halted one must not overwrite it
    get_ptr(`DMAC_OFF_LIST_UPPER);
    check(32'(ptr), 32'h70);
  endtask

  initial begin
    resetn = 1'b0;
    {psel, penable, pwrite, slow, ops_on} = 5'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    periph_req = 16'h0000;
    {errors, compares, cycles, wm_seen, end_seen} = '0;
    for (int i = 0; i < 64; i++) i_mem.mem[i] = 32'h10000000 + 32'h01010101 * i;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset();
    t_regs();
    t_direct();
    t_list();
    tally_and_finish();
  end
endmodule
